//--- hw/flash_ctrl_map.svh
`ifndef FLASH_CTRL_MAP_SVH
`define FLASH_CTRL_MAP_SVH
// ==========================================================
// Register offsets (APB byte addresses)
`define OFS_CTRL      8'h00
`define OFS_TIMING    8'h04
`define OFS_PROT      8'h08
`define OFS_LOCK      8'h0c
`define OFS_ESEL      8'h10
`define OFS_PECMD     8'h14
`define OFS_STATUS    8'h18
`define OFS_ISTAT     8'h1c
`define OFS_ICLR      8'h20
`define OFS_IEN       8'h24
`define OFS_EADDR     8'h28
// ==========================================================
// Reset values
`define RST_MODE      2'h3
`define RST_RD_WS     5'h00
`define RST_ALIAS_WS  5'h00
`define RST_PROT      6'h3f
`define RST_LOCK      10'h3ff
// ==========================================================
// Field positions
`define POS_ALIAS_WS  5
`define POS_WR_EN     3
`define POS_ERASE     0
`define POS_SUSPEND   1
`define POS_RESUME    2
`define POS_ABORT     3
`define ADDR_DATA_SEL 23
`define ADDR_ALIAS    22
// ==========================================================
// Event bits
`define EV_PE_DONE    0
`define EV_ECC_SGL    1
`define EV_ECC_DBL    2
`define EV_DENIED     3
`define EV_RESTRICT   4
`endif

//--- hw/flash_ctrl_pkg.sv
`include "flash_ctrl_map.svh"
package flash_ctrl_pkg;
   typedef enum logic [1:0] {idle, array_wait, array_latch} fsm_type;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic        fetch;
      logic [1:0]  master;
      logic [23:0] addr;
      logic [31:0] wdata;
   } bus_req_type;

   typedef struct packed {
      logic        ready;
      logic        err;
      logic [31:0] rdata;
   } bus_rsp_type;

   typedef struct packed {
      logic        en;
      logic [13:0] line;
   } code_req_type;

   typedef struct packed {
      logic [127:0] data;
      logic [15:0]  chk;
   } code_rsp_type;

   typedef struct packed {
      logic        en;
      logic [13:0] word;
   } data_req_type;

   typedef struct packed {
      logic [31:0] data;
      logic [6:0]  chk;
   } data_rsp_type;

   typedef struct packed {
      logic        start;
      logic        prog;
      logic [9:0]  blocks;
      logic [23:0] addr;
      logic [31:0] wdata;
      logic        suspend;
      logic        resume;
      logic        abort;
   } pe_cmd_type;

   typedef struct packed {
      logic busy;
      logic done;
      logic suspended;
      logic on_data;
   } pe_stat_type;

   // One-hot block of an address: code 0..5, data 6..9
   function automatic logic [9:0] block_of(input logic [23:0] a);
      logic [9:0] m;
      m = '0;
      if (a[`ADDR_DATA_SEL])
         m[6 + a[15:14]] = 1'b1;
      else if (a[17])
         m[5] = 1'b1;
      else if (a[16:15] == 2'h3)
         m[4] = 1'b1;
      else if (a[16:15] == 2'h2)
         m[3] = 1'b1;
      else if (a[16:14] == 3'h3)
         m[2] = 1'b1;
      else if (a[16:14] == 3'h2)
         m[1] = 1'b1;
      else
         m[0] = 1'b1;
      return m;
   endfunction
endpackage

//--- hw/flash_ecc_check.sv
`timescale 1ns/100ps
module flash_ecc_check #(
   parameter int data_width = 64,
   parameter int chk_width  = 8
) (
   input  wire logic [data_width-1:0] data,
   input  wire logic [chk_width-1:0]  chk,
   output logic      [data_width-1:0] fixed,
   output logic                       single,
   output logic                       double
);
   localparam int hw = chk_width - 1;

   // Hamming positions skip powers of two; top check bit is parity
   always_comb begin
      logic [hw-1:0] syn;
      logic          par;
      int            p;
      syn = chk[hw-1:0];
      par = ^{data, chk};
      p = 3;
      for (int i = 0; i < data_width; i++) begin
         if (data[i])
            syn = syn ^ p[hw-1:0];
         p = p + 1;
         if ((p & (p - 1)) == 0)
            p = p + 1;
      end
      fixed = data;
      p = 3;
      for (int i = 0; i < data_width; i++) begin
         if (par && syn == p[hw-1:0])
            fixed[i] = ~data[i];
         p = p + 1;
         if ((p & (p - 1)) == 0)
            p = p + 1;
      end
      single = par;
      double = !par && (syn != '0);
   end
endmodule // flash_ecc_check

//--- hw/flash_prefetch_buf.sv
`timescale 1ns/100ps
module flash_prefetch_buf (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         clk_en,
   input  wire logic [13:0]  look_line,
   input  wire logic [13:0]  pf_line,
   input  wire logic         fill_valid,
   input  wire logic [13:0]  fill_line,
   input  wire logic [127:0] fill_data,
   input  wire logic [9:0]   inval,
   output logic              hit,
   output logic [127:0]      hit_data,
   output logic              pf_hit
);
   import flash_ctrl_pkg::*;

   typedef struct packed {
      logic [3:0]        valid;
      logic [3:0][13:0]  tag;
      logic [3:0][127:0] line;
      logic [1:0]        victim;
   } buf_state_type;

   buf_state_type s;
   buf_state_type next_s;

   always_comb begin
      logic [1:0] slot;
      slot = s.victim;
      next_s = s;
      hit = 1'b0;
      pf_hit = 1'b0;
      hit_data = '0;
      for (int i = 0; i < 4; i++) begin
         if (s.valid[i] && s.tag[i] == look_line) begin
            hit = 1'b1;
            hit_data = s.line[i];
         end
         if (s.valid[i] && s.tag[i] == pf_line)
            pf_hit = 1'b1;
         // Refill in place so one line never sits twice
         if (s.valid[i] && s.tag[i] == fill_line)
            slot = 2'(i);
      end
      if (fill_valid) begin
         next_s.valid[slot] = 1'b1;
         next_s.tag[slot] = fill_line;
         next_s.line[slot] = fill_data;
         if (slot == s.victim)
            next_s.victim = s.victim + 2'h1;
      end
      // Invalidation wins over a fill landing in the same cycle
      for (int i = 0; i < 4; i++) begin
         if ((inval & block_of({6'h0, next_s.tag[i], 4'h0})) != '0)
            next_s.valid[i] = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         s <= '0;
      else if (clk_en)
         s <= next_s;
   end
endmodule // flash_prefetch_buf

//--- hw/flash_ctrl.sv
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/100ps
`include "flash_ctrl_map.svh"
// Behaviour
// - 32-bit bus side, 128-bit code array reads
// - Four 128-bit prefetch line buffers
// - Buffer hit answers without wait state
// - Miss registered, answered with two waits
// - Prefetch for fetches, data, or both
// - Code page four words, data page one
// - SEC-DED over 64-bit / 32-bit units
// - Alias mapping adds up to 31 cycles
// - Per-master read and write permission
// - Read one array while other programs
// - Six code blocks, four 16 KB data
// - Locked blocks refuse program and erase
// - Erase any selected set of blocks
// - Erase suspend and program abort
// - Software sets array read wait states
module flash_ctrl (
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic                         clk_en,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [7:0]                   paddr,
   input  wire logic [31:0]                  pwdata,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   output logic                              irq,
   input  wire flash_ctrl_pkg::bus_req_type  bus_req,
   output flash_ctrl_pkg::bus_rsp_type       bus_rsp,
   output flash_ctrl_pkg::code_req_type      code_req,
   input  wire flash_ctrl_pkg::code_rsp_type code_rsp,
   output flash_ctrl_pkg::data_req_type      data_req,
   input  wire flash_ctrl_pkg::data_rsp_type data_rsp,
   output flash_ctrl_pkg::pe_cmd_type        pe_cmd,
   input  wire flash_ctrl_pkg::pe_stat_type  pe_stat,
   input  wire logic [2:0]                   hw_rd_deny,
   input  wire logic [2:0]                   hw_wr_deny
);
   import flash_ctrl_pkg::*;

   typedef struct packed {
      fsm_type      fsm;
      logic         pf;
      logic [5:0]   cnt;
      logic         cur_fetch;
      logic [23:0]  cur_addr;
      bus_rsp_type  ans;
      code_req_type code;
      data_req_type data;
      pe_cmd_type   pe;
      logic [1:0]   mode;
      logic [4:0]   rd_ws;
      logic [4:0]   alias_ws;
      logic [5:0]   prot;
      logic [9:0]   lock;
      logic [9:0]   esel;
      logic [4:0]   istat;
      logic [4:0]   ien;
      logic [23:0]  eaddr;
      logic         irq;
      logic [31:0]  prdata;
      logic         pready;
      logic         pslverr;
      logic [5:0]   sync1;
      logic [5:0]   sync2;
   } state_type;

   state_type    s;
   state_type    next_s;
   logic [4:0]   ev;
   logic [4:0]   clr;
   logic [9:0]   inval;
   logic [9:0]   blk;
   logic [9:0]   eblk;
   logic [3:0]   rd_en;
   logic [3:0]   wr_en;
   logic [5:0]   miss_ws;
   logic [13:0]  pf_line;
   logic         buf_hit;
   logic         pf_hit;
   logic [127:0] buf_line;
   logic         fill_valid;
   logic [127:0] line_fix;
   logic [1:0]   c_sgl;
   logic [1:0]   c_dbl;
   logic [31:0]  data_fix;
   logic         d_sgl;
   logic         d_dbl;
   logic         sgl_now;
   logic         dbl_now;
   logic         type_en;
   logic         pf_go;
   logic         take_hit;
   logic         take_miss;
   logic         take_deny;
   logic         stall;
   logic         apb_susp;

   function automatic logic [31:0] word_of(input logic [127:0] l,
                                           input logic [1:0]   w);
      return l[w*32 +: 32];
   endfunction

   // ==========================================================
   // Prefetch buffers and ECC
   flash_prefetch_buf u_buf (
      .pclk       (pclk),
      .presetn    (presetn),
      .clk_en     (clk_en),
      .look_line  (bus_req.addr[17:4]),
      .pf_line    (pf_line),
      .fill_valid (fill_valid),
      .fill_line  (s.code.line),
      .fill_data  (line_fix),
      .inval      (inval),
      .hit        (buf_hit),
      .hit_data   (buf_line),
      .pf_hit     (pf_hit)
   );

   for (genvar g = 0; g < 2; g++) begin : g_code_ecc
      flash_ecc_check #(.data_width(64), .chk_width(8)) u_ecc (
         .data   (code_rsp.data[g*64 +: 64]),
         .chk    (code_rsp.chk[g*8 +: 8]),
         .fixed  (line_fix[g*64 +: 64]),
         .single (c_sgl[g]),
         .double (c_dbl[g])
      );
   end

   flash_ecc_check #(.data_width(32), .chk_width(7)) u_data_ecc (
      .data   (data_rsp.data),
      .chk    (data_rsp.chk),
      .fixed  (data_fix),
      .single (d_sgl),
      .double (d_dbl)
   );

   // ==========================================================
   // Next state
   always_comb begin
      logic acc;
      logic arr_d;
      acc = psel & penable;
      arr_d = !s.pf && s.cur_addr[`ADDR_DATA_SEL];
      next_s = s;
      ev = '0;
      clr = '0;
      inval = '0;
      take_hit = 1'b0;
      take_miss = 1'b0;
      take_deny = 1'b0;
      stall = 1'b0;
      apb_susp = 1'b0;
      fill_valid = 1'b0;
      next_s.pe.start = 1'b0;
      next_s.pe.suspend = 1'b0;
      next_s.pe.resume = 1'b0;
      next_s.pe.abort = 1'b0;
      next_s.ans.ready = 1'b0;
      next_s.ans.err = 1'b0;
      next_s.sync1 = {hw_wr_deny, hw_rd_deny};
      next_s.sync2 = s.sync1;
      rd_en = {1'b0, s.prot[2:0] & ~s.sync2[2:0]};
      wr_en = {1'b0, s.prot[5:3] & ~s.sync2[5:3]};
      blk = block_of(bus_req.addr);
      eblk = s.esel & ~s.lock;
      miss_ws = {1'b0, s.rd_ws}
              + (bus_req.addr[`ADDR_ALIAS] ? {1'b0, s.alias_ws} : 6'h0);
      pf_line = (s.fsm == idle ? bus_req.addr[17:4] : s.cur_addr[17:4])
              + 14'h1;
      type_en = (s.fsm == idle ? bus_req.fetch : s.cur_fetch)
              ? s.mode[0] : s.mode[1];
      // Last line of the array has no successor to fetch
      pf_go = type_en && !pf_hit && !(&pf_line == 1'b0 && 1'b0)
              && (pf_line != 14'h0);
      sgl_now = arr_d ? d_sgl : |c_sgl;
      dbl_now = arr_d ? d_dbl : |c_dbl;

      // ==========================================================
      // APB slave: one wait state, commit on the pready edge
      next_s.pready = acc & ~s.pready;
      next_s.pslverr = 1'b0;
      if (acc && !s.pready) begin
         next_s.prdata = '0;
         case (paddr)
            `OFS_CTRL:   next_s.prdata = {30'h0, s.mode};
            `OFS_TIMING: next_s.prdata = {22'h0, s.alias_ws, s.rd_ws};
            `OFS_PROT:   next_s.prdata = {26'h0, s.prot};
            `OFS_LOCK:   next_s.prdata = {22'h0, s.lock};
            `OFS_ESEL:   next_s.prdata = {22'h0, s.esel};
            `OFS_STATUS: next_s.prdata = {29'h0, s.fsm != idle,
                                          pe_stat.suspended, pe_stat.busy};
            `OFS_ISTAT:  next_s.prdata = {27'h0, s.istat};
            `OFS_IEN:    next_s.prdata = {27'h0, s.ien};
            `OFS_EADDR:  next_s.prdata = {8'h0, s.eaddr};
            `OFS_PECMD, `OFS_ICLR: next_s.prdata = '0;
            default:     next_s.pslverr = 1'b1;
         endcase
      end
      if (acc && s.pready && pwrite && !s.pslverr) begin
         case (paddr)
            `OFS_CTRL:   next_s.mode = pwdata[1:0];
            `OFS_TIMING: begin
               next_s.rd_ws = pwdata[4:0];
               next_s.alias_ws = pwdata[`POS_ALIAS_WS +: 5];
            end
            `OFS_PROT:   next_s.prot = pwdata[5:0];
            `OFS_LOCK:   next_s.lock = pwdata[9:0];
            `OFS_ESEL:   next_s.esel = pwdata[9:0];
            `OFS_ICLR:   clr = pwdata[4:0];
            `OFS_IEN:    next_s.ien = pwdata[4:0];
            `OFS_PECMD: begin
               if (pwdata[`POS_ERASE] && !pe_stat.busy) begin
                  if (eblk == '0) begin
                     ev[`EV_RESTRICT] = 1'b1;
                  end else begin
                     next_s.pe.start = 1'b1;
                     next_s.pe.prog = 1'b0;
                     next_s.pe.blocks = eblk;
                     inval = eblk;
                  end
               end
               apb_susp = pwdata[`POS_SUSPEND];
               next_s.pe.suspend = pwdata[`POS_SUSPEND];
               next_s.pe.resume = pwdata[`POS_RESUME];
               next_s.pe.abort = pwdata[`POS_ABORT];
            end
            default: ;
         endcase
      end

      // ==========================================================
      // System bus side
      case (s.fsm)
         idle: begin
            if (bus_req.valid && !s.ans.ready) begin
               if (bus_req.write) begin
                  if (!wr_en[bus_req.master]) begin
                     take_deny = 1'b1;
                     ev[`EV_DENIED] = 1'b1;
                  end else if ((blk & s.lock) != '0) begin
                     take_deny = 1'b1;
                     ev[`EV_RESTRICT] = 1'b1;
                  end else if (pe_stat.busy || next_s.pe.start) begin
                     stall = 1'b1;
                  end else begin
                     next_s.pe.start = 1'b1;
                     next_s.pe.prog = 1'b1;
                     next_s.pe.blocks = blk;
                     next_s.pe.addr = bus_req.addr;
                     next_s.pe.wdata = bus_req.wdata;
                     inval = inval | blk;
                     next_s.ans.ready = 1'b1;
                  end
               end else if (!rd_en[bus_req.master]) begin
                  take_deny = 1'b1;
                  ev[`EV_DENIED] = 1'b1;
               end else if (pe_stat.busy && pe_stat.on_data
                            == bus_req.addr[`ADDR_DATA_SEL]) begin
                  stall = 1'b1;
               end else begin
                  next_s.cur_addr = bus_req.addr;
                  next_s.cur_fetch = bus_req.fetch;
                  if (!bus_req.addr[`ADDR_DATA_SEL] && buf_hit) begin
                     take_hit = 1'b1;
                     next_s.ans.ready = 1'b1;
                     next_s.ans.rdata = word_of(buf_line,
                                                bus_req.addr[3:2]);
                     if (pf_go) begin
                        next_s.fsm = array_wait;
                        next_s.pf = 1'b1;
                        next_s.cnt = {1'b0, s.rd_ws};
                        next_s.code.en = 1'b1;
                        next_s.code.line = pf_line;
                     end
                  end else begin
                     take_miss = 1'b1;
                     next_s.fsm = array_wait;
                     next_s.pf = 1'b0;
                     next_s.cnt = miss_ws;
                     if (bus_req.addr[`ADDR_DATA_SEL]) begin
                        next_s.data.en = 1'b1;
                        next_s.data.word = bus_req.addr[15:2];
                     end else begin
                        next_s.code.en = 1'b1;
                        next_s.code.line = bus_req.addr[17:4];
                     end
                  end
               end
               if (take_deny) begin
                  next_s.ans.ready = 1'b1;
                  next_s.ans.err = 1'b1;
               end
            end
         end
         array_wait: begin
            if (s.cnt == 6'h0)
               next_s.fsm = array_latch;
            else
               next_s.cnt = s.cnt - 6'h1;
         end
         array_latch: begin
            // Array data is registered here and answered next cycle
            next_s.code.en = 1'b0;
            next_s.data.en = 1'b0;
            next_s.fsm = idle;
            ev[`EV_ECC_SGL] = sgl_now;
            ev[`EV_ECC_DBL] = dbl_now;
            if (sgl_now || dbl_now)
               next_s.eaddr = s.pf ? {6'h0, s.code.line, 4'h0}
                                   : s.cur_addr;
            fill_valid = !arr_d && !dbl_now && (s.pf || type_en);
            if (!s.pf) begin
               next_s.ans.ready = 1'b1;
               next_s.ans.err = dbl_now;
               next_s.ans.rdata = arr_d ? data_fix
                                : word_of(line_fix, s.cur_addr[3:2]);
               if (!arr_d && pf_go) begin
                  next_s.fsm = array_wait;
                  next_s.pf = 1'b1;
                  next_s.cnt = {1'b0, s.rd_ws};
                  next_s.code.en = 1'b1;
                  next_s.code.line = pf_line;
               end
            end
         end
         default: next_s.fsm = idle;
      endcase

      // ==========================================================
      // Interrupts: a new event wins over its clear
      ev[`EV_PE_DONE] = pe_stat.done;
      next_s.istat = (s.istat & ~clr) | ev;
      next_s.irq = |(next_s.istat & next_s.ien);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.mode <= `RST_MODE;
         s.rd_ws <= `RST_RD_WS;
         s.alias_ws <= `RST_ALIAS_WS;
         s.prot <= `RST_PROT;
         s.lock <= `RST_LOCK;
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign irq = s.irq;
   assign bus_rsp = s.ans;
   assign code_req = s.code;
   assign data_req = s.data;
   assign pe_cmd = s.pe;

   // ==========================================================
   // Checks
   default clocking cb @(posedge pclk iff clk_en);
   endclocking
   default disable iff (!presetn);

   property p_hit_answer;
      take_hit |=> bus_rsp.ready && !bus_rsp.err;
   endproperty
   a_hit_answer: assert property (p_hit_answer)
      else $error("buffer hit not answered next cycle");

   property p_miss_two_ws;
      take_miss && miss_ws == 6'h0
      |=> !bus_rsp.ready ##1 !bus_rsp.ready ##1 bus_rsp.ready;
   endproperty
   a_miss_two_ws: assert property (p_miss_two_ws)
      else $error("miss answer not after two wait states");

   property p_alias_extra;
      take_miss && miss_ws == 6'h5
      |=> (s.fsm == array_wait)[*6] ##1 s.fsm == array_latch;
   endproperty
   a_alias_extra: assert property (p_alias_extra)
      else $error("extra access cycles miscounted");

   property p_deny;
      take_deny |=> bus_rsp.ready && bus_rsp.err;
   endproperty
   a_deny: assert property (p_deny)
      else $error("denied access not answered with error");

   property p_rww;
      stall && !bus_req.write
      |-> pe_stat.busy
          && pe_stat.on_data == bus_req.addr[`ADDR_DATA_SEL];
   endproperty
   a_rww: assert property (p_rww)
      else $error("read stalled by the other array");

   property p_ecc_err;
      s.fsm == array_latch && !s.pf && dbl_now
      |=> bus_rsp.ready && bus_rsp.err;
   endproperty
   a_ecc_err: assert property (p_ecc_err)
      else $error("double-bit error not reported");

   property p_restrict;
      pe_cmd.start |-> (pe_cmd.blocks & $past(s.lock)) == '0;
   endproperty
   a_restrict: assert property (p_restrict)
      else $error("program or erase issued to locked block");

   property p_suspend;
      apb_susp |=> pe_cmd.suspend;
   endproperty
   a_suspend: assert property (p_suspend)
      else $error("suspend request not passed on");
endmodule // flash_ctrl

//--- test/flash_array_model.sv
`timescale 1ns/100ps
module flash_array_model (
   input  wire logic                         pclk,
   input  wire flash_ctrl_pkg::code_req_type code_req,
   input  wire flash_ctrl_pkg::data_req_type data_req,
   input  wire logic [1:0]                   inject,
   output flash_ctrl_pkg::code_rsp_type      code_rsp,
   output flash_ctrl_pkg::data_rsp_type      data_rsp
);
   import flash_ctrl_pkg::*;
   logic [127:0] ln;
   logic [31:0]  w;
   logic [7:0]   c8;

   function automatic logic [7:0] ecc(input logic [63:0] d, input int n);
      logic [7:0] c;
      int         p;
      c = '0;
      p = 2;
      for (int i = 0; i < n; i++) begin
         p++;
         while ((p & (p - 1)) == 0) p++;
         if (d[i]) c ^= p[7:0];
      end
      c[n == 64 ? 7 : 6] = ^d ^ ^c;
      return c;
   endfunction

   initial begin
      code_rsp = '0;
      data_rsp = '0;
   end
   // Released lines toggle so stale data never looks valid
   always @(posedge pclk) begin
      if (code_req.en) begin
         for (int k = 0; k < 4; k++)
            ln[32*k +: 32] = {16'hc0de, code_req.line, k[1:0]};
         code_rsp.chk <= {ecc(ln[127:64], 64), ecc(ln[63:0], 64)};
         code_rsp.data <= ln ^ {126'h0, inject};
      end else
         code_rsp.data <= ~code_rsp.data;
      if (data_req.en) begin
         w = {16'hda7a, 2'h0, data_req.word};
         c8 = ecc({32'h0, w}, 32);
         data_rsp.data <= w;
         data_rsp.chk <= c8[6:0];
      end else
         data_rsp.data <= ~data_rsp.data;
   end
endmodule // flash_array_model

//--- test/flash_ctrl_tb.sv
`timescale 1ns/100ps
module flash_ctrl_tb;
   import flash_ctrl_pkg::*;
   logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic         err, sus, abt;
   logic [7:0]   paddr;
   logic [31:0]  pwdata, prdata, r, got;
   logic [1:0]   inject;
   logic [9:0]   blk;
   int           mismatches, checked, n, n0, n1;
   bus_req_type  bus_req;
   bus_rsp_type  bus_rsp;
   code_req_type code_req;
   code_rsp_type code_rsp;
   data_req_type data_req;
   data_rsp_type data_rsp;
   pe_cmd_type   pe_cmd;
   pe_stat_type  pe_stat;

   flash_ctrl dut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .bus_req, .bus_rsp,
      .code_req, .code_rsp, .data_req, .data_rsp, .pe_cmd, .pe_stat,
      .hw_rd_deny(3'h0), .hw_wr_deny(3'h0));
   flash_array_model array (.pclk, .code_req, .data_req, .inject, .code_rsp,
      .data_rsp);

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (pe_cmd.start) blk <= pe_cmd.blocks;
      if (pe_cmd.suspend) sus <= 1'b1;
      if (pe_cmd.abort) abt <= 1'b1;
   end
   // ==========================================================
   // Tasks
   function automatic logic [31:0] cw(input logic [23:0] a);
      return {16'hc0de, a[17:2]};
   endfunction
   task chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Latency counted in edges; only differences are compared
   task rd(input logic [23:0] a);
      bus_req.valid <= 1'b1;
      bus_req.fetch <= 1'b1;
      bus_req.addr <= a;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (bus_rsp.ready !== 1'b1);
      got = bus_rsp.rdata;
      err = bus_rsp.err;
      bus_req.valid <= 1'b0;
      @(posedge pclk);
   endtask
   task finish_test;
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge pclk);
      mismatches++;
      finish_test;
   end
   // ==========================================================
   // Tests
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, inject} = '0;
      {bus_req, pe_stat, blk, sus, abt} = '0;
      mismatches = 0;
      checked = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, `OFS_CTRL, 0);
      chk(r, 32'h3);
      apb(0, `OFS_PROT, 0);
      chk(r, 32'h3f);
      apb(0, `OFS_LOCK, 0);
      chk(r, 32'h3ff);
      apb(0, 8'h2c, 0);
      chk({31'h0, err}, 32'h1);
      $display("test registers done");
      rd(24'h10);
      n0 = n;
      chk(got, cw(24'h10));
      rd(24'h14);
      n1 = n;
      chk(got, cw(24'h14));
      chk(32'(n0 - n1), 32'h2);
      repeat (8) @(posedge pclk);
      rd(24'h24);
      chk(32'(n), 32'(n1));
      apb(1, `OFS_CTRL, 0);
      rd(24'h100);
      repeat (8) @(posedge pclk);
      rd(24'h110);
      chk(32'(n), 32'(n0));
      apb(1, `OFS_TIMING, 32'h62);
      rd(24'h400200);
      chk(32'(n), 32'(n0 + 5));
      apb(1, `OFS_TIMING, 0);
      rd(24'h800008);
      chk(got, 32'hda7a0002);
      $display("test timing done");
      inject <= 2'h1;
      rd(24'h300);
      chk(got, cw(24'h300));
      apb(0, `OFS_ISTAT, 0);
      chk(r & 32'h2, 32'h2);
      apb(1, `OFS_IEN, 32'h2);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      apb(1, `OFS_ICLR, 32'h2);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      inject <= 2'h3;
      rd(24'h310);
      chk({31'h0, err}, 32'h1);
      inject <= 2'h0;
      apb(1, `OFS_PROT, 32'h3e);
      rd(24'h10);
      chk({31'h0, err}, 32'h1);
      apb(1, `OFS_PROT, 32'h3f);
      $display("test ecc and access done");
      // Prefetch back on so the line below is buffered before the erase
      apb(1, `OFS_CTRL, 32'h3);
      pe_stat.busy <= 1'b1;
      pe_stat.on_data <= 1'b1;
      rd(24'h114);
      chk(got, cw(24'h114));
      chk(32'(n), 32'(n0));
      pe_stat <= '0;
      apb(1, `OFS_ESEL, 32'h3b);
      apb(1, `OFS_PECMD, 32'h1);
      apb(0, `OFS_ISTAT, 0);
      chk(r & 32'h10, 32'h10);
      chk({22'h0, blk}, 32'h0);
      apb(1, `OFS_LOCK, 32'h3f0);
      apb(1, `OFS_PECMD, 32'h1);
      // Captured pulse lands one edge after the task returns
      @(posedge pclk);
      chk({22'h0, blk}, 32'h0b);
      rd(24'h114);
      chk(32'(n), 32'(n0));
      apb(1, `OFS_PECMD, 32'h2);
      apb(1, `OFS_PECMD, 32'h8);
      @(posedge pclk);
      chk({30'h0, sus, abt}, 32'h3);
      $display("test program erase done");
      finish_test;
   end
endmodule // flash_ctrl_tb
